// *** rtl/podc_core.sv ***
// Device-side protocol engine for PIO data-out and DMA commands.
// Assumes an AXI4-Lite master and firmware pulsing the event register.
//
// How it works
// - PIO command: busy, quiet
// - First block: straight to transfer
// - Later block: pending, idis picks path
// - Status read acks ready-irq
// - Data writes fill block
// - Done or abort: pending, idle
// - One interrupt per DMA command
// - DMA command: busy, quiet
// - DMA transfer quiet; burst re-prepares
// - DMA done or abort: idle
`timescale 1ns/100ps
`include "podc_defs.svh"

module podc_core (
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // Protocol pins
   output logic             intrq_out,
   output logic             dmarq_out,
   output logic             irq_out
);

   // =====================================================================
   // Bus decode
   // =====================================================================
   logic        wr_go;
   logic        rd_go;
   logic [7:0]  rd_addr;
   logic        ev_ready;
   logic        ev_abort;
   logic        ev_burst;
   logic        ev_done;
   logic        cmd_pio;
   logic        cmd_dma;
   logic        data_wr;
   logic        status_rd;
   logic        irqstat_rd;

   // Write accepted when both halves are present and no response pends
   assign wr_go = s_axi_awvalid_in & s_axi_wvalid_in & ~s_axi_bvalid_out;
   assign rd_go = s_axi_arvalid_in & ~s_axi_rvalid_out;
   assign rd_addr = {s_axi_araddr_in[7:2], 2'b00};

   function automatic logic wr_hit(input logic [7:0] off);
      wr_hit = wr_go && ({s_axi_awaddr_in[7:2], 2'b00} == off)
               && s_axi_wstrb_in[0];
   endfunction

   assign cmd_pio  = wr_hit(`PODC_OFF_CMD)
                     && s_axi_wdata_in[7:0] == `PODC_CMD_PIO_OUT;
   assign cmd_dma  = wr_hit(`PODC_OFF_CMD)
                     && s_axi_wdata_in[7:0] == `PODC_CMD_DMA;
   assign data_wr  = wr_hit(`PODC_OFF_DATA);
   assign ev_ready = wr_hit(`PODC_OFF_EVENT) & s_axi_wdata_in[`PODC_EV_READY];
   assign ev_abort = wr_hit(`PODC_OFF_EVENT) & s_axi_wdata_in[`PODC_EV_ABORT];
   assign ev_burst = wr_hit(`PODC_OFF_EVENT)
                     & s_axi_wdata_in[`PODC_EV_BURST_END];
   assign ev_done  = wr_hit(`PODC_OFF_EVENT) & s_axi_wdata_in[`PODC_EV_DONE];
   assign status_rd  = rd_go && rd_addr == `PODC_OFF_STATUS;
   assign irqstat_rd = rd_go && rd_addr == `PODC_OFF_IRQ_STAT;

   // =====================================================================
   // Protocol state
   // =====================================================================
   podc_pkg::podc_state_e state_ff, nxt_state;
   logic        bsy_ff, nxt_bsy;
   logic        drq_ff, nxt_drq;
   logic        err_ff, nxt_err;
   logic        pend_ff, nxt_pend;
   logic        intrq_ff, nxt_intrq;
   logic        dmarq_ff, nxt_dmarq;
   logic        first_ff, nxt_first;
   logic        idis_ff, nxt_idis;
   logic [15:0] blk_ff, nxt_blk;
   logic [15:0] wcnt_ff, nxt_wcnt;
   logic [15:0] bcnt_ff, nxt_bcnt;
   logic [31:0] last_word_ff, nxt_last_word;
   logic        blk_end;
   logic        ev_blk, ev_fin;

   assign blk_end = (wcnt_ff + 16'h0001) == blk_ff;

   // Next protocol state; busy is set on the same edge as the command
   always_comb begin
      nxt_state     = state_ff;
      nxt_bsy       = bsy_ff;
      nxt_drq       = drq_ff;
      nxt_err       = err_ff;
      nxt_pend      = pend_ff;
      nxt_intrq     = intrq_ff;
      nxt_dmarq     = dmarq_ff;
      nxt_first     = first_ff;
      nxt_wcnt      = wcnt_ff;
      nxt_bcnt      = bcnt_ff;
      nxt_last_word = last_word_ff;
      ev_blk        = 1'b0;
      ev_fin        = 1'b0;
      unique case (state_ff)
         podc_pkg::PODC_IDLE_QUIET, podc_pkg::PODC_IDLE_IRQ: begin
            // Status read in idle acknowledges a completion interrupt
            if (status_rd) begin
               nxt_intrq = 1'b0;
               nxt_pend  = 1'b0;
            end
            if (cmd_pio || cmd_dma) begin
               nxt_bsy   = 1'b1;
               nxt_drq   = 1'b0;
               nxt_intrq = 1'b0;
               nxt_pend  = 1'b0;
               nxt_err   = 1'b0;
               nxt_first = 1'b1;
               nxt_bcnt  = 16'h0000;
               nxt_state = cmd_pio ? podc_pkg::PODC_OUT_PREPARE
                                   : podc_pkg::PODC_DMA_PREPARE;
            end
         end
         podc_pkg::PODC_OUT_PREPARE: begin
            if (ev_abort || ev_done) begin
               nxt_pend  = 1'b1;
               nxt_err   = ev_abort;
               nxt_bsy   = 1'b0;
               nxt_intrq = ~idis_ff;
               ev_fin    = 1'b1;
               nxt_state = idis_ff ? podc_pkg::PODC_IDLE_QUIET
                                   : podc_pkg::PODC_IDLE_IRQ;
            end else if (ev_ready) begin
               nxt_wcnt  = 16'h0000;
               nxt_first = 1'b0;
               if (first_ff) begin
                  nxt_bsy   = 1'b0;
                  nxt_drq   = 1'b1;
                  nxt_state = podc_pkg::PODC_OUT_XFER;
               end else begin
                  nxt_pend  = 1'b1;
                  nxt_bsy   = 1'b0;
                  nxt_drq   = 1'b1;
                  nxt_intrq = ~idis_ff;
                  nxt_state = idis_ff ? podc_pkg::PODC_OUT_XFER
                                      : podc_pkg::PODC_OUT_RDY_IRQ;
               end
            end
         end
         podc_pkg::PODC_OUT_RDY_IRQ: begin
            if (status_rd) begin
               nxt_pend  = 1'b0;
               nxt_intrq = 1'b0;
               nxt_state = podc_pkg::PODC_OUT_XFER;
            end
         end
         podc_pkg::PODC_OUT_XFER: begin
            // Status reads here leave the flags alone
            if (data_wr) begin
               nxt_last_word = s_axi_wdata_in;
               nxt_wcnt      = wcnt_ff + 16'h0001;
               if (blk_end) begin
                  nxt_bsy   = 1'b1;
                  nxt_drq   = 1'b0;
                  nxt_bcnt  = bcnt_ff + 16'h0001;
                  ev_blk    = 1'b1;
                  nxt_state = podc_pkg::PODC_OUT_PREPARE;
               end
            end
         end
         podc_pkg::PODC_DMA_PREPARE: begin
            if (ev_abort || ev_done) begin
               nxt_pend  = 1'b1;
               nxt_err   = ev_abort;
               nxt_bsy   = 1'b0;
               nxt_intrq = ~idis_ff;
               ev_fin    = 1'b1;
               nxt_state = idis_ff ? podc_pkg::PODC_IDLE_QUIET
                                   : podc_pkg::PODC_IDLE_IRQ;
            end else if (ev_ready) begin
               nxt_bsy   = 1'b0;
               nxt_drq   = 1'b1;
               nxt_dmarq = 1'b1;
               nxt_state = podc_pkg::PODC_DMA_XFER;
            end
         end
         podc_pkg::PODC_DMA_XFER: begin
            if (ev_abort || ev_done) begin
               nxt_pend  = 1'b1;
               nxt_err   = ev_abort;
               nxt_bsy   = 1'b0;
               nxt_drq   = 1'b0;
               nxt_dmarq = 1'b0;
               nxt_intrq = ~idis_ff;
               ev_fin    = 1'b1;
               nxt_state = idis_ff ? podc_pkg::PODC_IDLE_QUIET
                                   : podc_pkg::PODC_IDLE_IRQ;
            end else if (ev_burst) begin
               nxt_bsy   = 1'b1;
               nxt_drq   = 1'b0;
               nxt_dmarq = 1'b0;
               nxt_state = podc_pkg::PODC_DMA_PREPARE;
            end
         end
      endcase
   end

   // Control register feeds the interrupt gating above
   always_comb begin
      nxt_idis = idis_ff;
      nxt_blk  = blk_ff;
      if (wr_hit(`PODC_OFF_CTRL)) begin
         nxt_idis = s_axi_wdata_in[`PODC_CT_IDIS];
      end
      // Zero length is meaningless, so it is kept out
      if (wr_hit(`PODC_OFF_XFER) && s_axi_wdata_in[15:0] != 16'h0000) begin
         nxt_blk = s_axi_wdata_in[15:0];
      end
   end

   // =====================================================================
   // Interrupt status, mask and bus responses
   // =====================================================================
   logic [2:0]  ist_ff, nxt_ist;
   logic [2:0]  imask_ff, nxt_imask;
   logic        irq_ff, nxt_irq;
   logic        awr_ff, nxt_awr;
   logic        arr_ff, nxt_arr;
   logic        bv_ff, nxt_bv;
   logic [1:0]  br_ff, nxt_br;
   logic        rv_ff, nxt_rv;
   logic [1:0]  rr_ff, nxt_rr;
   logic [31:0] rd_ff, nxt_rd;
   logic [2:0]  ev_vec;
   logic        wr_map;

   assign ev_vec = {ev_fin, ev_blk, nxt_intrq & ~intrq_ff};
   assign wr_map = {s_axi_awaddr_in[7:2], 2'b00} <= `PODC_OFF_EVENT
                   && {s_axi_awaddr_in[7:2], 2'b00} != `PODC_OFF_STATUS;

   // Read clears; a new event in the same cycle wins over the clear
   always_comb begin
      nxt_ist   = (irqstat_rd ? 3'h0 : ist_ff) | ev_vec;
      nxt_imask = imask_ff;
      if (wr_hit(`PODC_OFF_IRQ_MASK)) begin
         nxt_imask = s_axi_wdata_in[2:0];
      end
      nxt_irq = |(nxt_ist & nxt_imask);
   end

   // Single-beat slave: ready pulses with the accepted handshake
   always_comb begin
      nxt_awr = wr_go;
      nxt_arr = rd_go;
      nxt_bv  = s_axi_bvalid_out & ~s_axi_bready_in;
      nxt_br  = br_ff;
      nxt_rv  = s_axi_rvalid_out & ~s_axi_rready_in;
      nxt_rr  = rr_ff;
      nxt_rd  = rd_ff;
      if (wr_go) begin
         nxt_bv = 1'b1;
         nxt_br = wr_map ? 2'b00 : 2'b10;
      end
      if (rd_go) begin
         nxt_rv = 1'b1;
         nxt_rr = 2'b00;
         unique case (rd_addr)
            `PODC_OFF_STATUS, 8'h00:
               nxt_rd = {24'h000000, bsy_ff, 3'h0, drq_ff, 2'h0, err_ff};
            `PODC_OFF_DATA:     nxt_rd = last_word_ff;
            `PODC_OFF_CTRL:     nxt_rd = {30'h0, idis_ff, 1'b0};
            `PODC_OFF_IRQ_STAT: nxt_rd = {29'h0, ist_ff};
            `PODC_OFF_IRQ_MASK: nxt_rd = {29'h0, imask_ff};
            `PODC_OFF_XFER:     nxt_rd = {bcnt_ff, blk_ff};
            `PODC_OFF_EVENT:    nxt_rd = {25'h0, state_ff};
            default: begin
               nxt_rd = 32'h00000000;
               nxt_rr = 2'b10;
            end
         endcase
      end
   end

   // =====================================================================
   // Registers
   // =====================================================================
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff <= podc_pkg::PODC_IDLE_QUIET;
         bsy_ff <= 1'b0;
         drq_ff <= 1'b0;
         err_ff <= 1'b0;
         pend_ff <= 1'b0;
         intrq_ff <= 1'b0;
         dmarq_ff <= 1'b0;
         first_ff <= 1'b0;
         idis_ff <= 1'b0;
         blk_ff <= `PODC_BLK_WORDS;
         wcnt_ff <= 16'h0000;
         bcnt_ff <= 16'h0000;
         last_word_ff <= 32'h00000000;
         ist_ff <= 3'h0;
         imask_ff <= 3'h0;
         irq_ff <= 1'b0;
         awr_ff <= 1'b0;
         arr_ff <= 1'b0;
         bv_ff <= 1'b0;
         br_ff <= 2'b00;
         rv_ff <= 1'b0;
         rr_ff <= 2'b00;
         rd_ff <= 32'h00000000;
      end else begin
         state_ff <= nxt_state;
         bsy_ff <= nxt_bsy;
         drq_ff <= nxt_drq;
         err_ff <= nxt_err;
         pend_ff <= nxt_pend;
         intrq_ff <= nxt_intrq;
         dmarq_ff <= nxt_dmarq;
         first_ff <= nxt_first;
         idis_ff <= nxt_idis;
         blk_ff <= nxt_blk;
         wcnt_ff <= nxt_wcnt;
         bcnt_ff <= nxt_bcnt;
         last_word_ff <= nxt_last_word;
         ist_ff <= nxt_ist;
         imask_ff <= nxt_imask;
         irq_ff <= nxt_irq;
         awr_ff <= nxt_awr;
         arr_ff <= nxt_arr;
         bv_ff <= nxt_bv;
         br_ff <= nxt_br;
         rv_ff <= nxt_rv;
         rr_ff <= nxt_rr;
         rd_ff <= nxt_rd;
      end
   end

   // Outputs straight from flops
   assign s_axi_awready_out = awr_ff;
   assign s_axi_wready_out = awr_ff;
   assign s_axi_bvalid_out = bv_ff;
   assign s_axi_bresp_out = br_ff;
   assign s_axi_arready_out = arr_ff;
   assign s_axi_rvalid_out = rv_ff;
   assign s_axi_rresp_out = rr_ff;
   assign s_axi_rdata_out = rd_ff;
   assign intrq_out = intrq_ff;
   assign dmarq_out = dmarq_ff;
   assign irq_out = irq_ff;

endmodule

// *** rtl/podc_defs.svh ***
// Constants for the device-side command protocol engine.
// Assumes inclusion by bare name from the core module.
`ifndef PODC_DEFS_SVH
`define PODC_DEFS_SVH

// Register byte offsets on the AXI4-Lite slave
`define PODC_OFF_CMD 8'h00
`define PODC_OFF_STATUS 8'h04
`define PODC_OFF_DATA 8'h08
`define PODC_OFF_CTRL 8'h0C
`define PODC_OFF_IRQ_STAT 8'h10
`define PODC_OFF_IRQ_MASK 8'h14
`define PODC_OFF_XFER 8'h18
`define PODC_OFF_EVENT 8'h1C

// Command codes written to the command register
`define PODC_CMD_PIO_OUT 8'h01
`define PODC_CMD_DMA 8'h02

// Status register bit positions
`define PODC_ST_ERR 0
`define PODC_ST_DRQ 3
`define PODC_ST_BSY 7

// Control register bit positions
`define PODC_CT_IDIS 1

// Event register bits (device-side firmware events, write one to pulse)
`define PODC_EV_READY 0
`define PODC_EV_ABORT 1
`define PODC_EV_BURST_END 2
`define PODC_EV_DONE 3

// Interrupt status bits
`define PODC_IS_INTRQ 0
`define PODC_IS_BLOCK 1
`define PODC_IS_DONE 2

// Busy must rise within this time after the command write
`define PODC_BSY_MAX_NS 400
`define PODC_CLK_NS 8
`define PODC_BSY_CYC ((`PODC_BSY_MAX_NS) / (`PODC_CLK_NS))

// Default words per data block
`define PODC_BLK_WORDS 16'h0100

`endif

// *** rtl/podc_pkg.sv ***
// Types for the device-side command protocol engine.
// Assumes podc_defs.svh sits on the include path.
package podc_pkg;
   // One-hot protocol states
   typedef enum logic [6:0] {
      PODC_IDLE_QUIET  = 7'h01,
      PODC_IDLE_IRQ    = 7'h02,
      PODC_OUT_PREPARE = 7'h04,
      PODC_OUT_XFER    = 7'h08,
      PODC_OUT_RDY_IRQ = 7'h10,
      PODC_DMA_PREPARE = 7'h20,
      PODC_DMA_XFER    = 7'h40
   } podc_state_e;
endpackage

// *** tb/podc_chk.sv ***
// Protocol checker for the device-side command engine.
// Assumes it is bound to podc_core and sees only that module's ports.
`timescale 1ns/100ps

module podc_chk (
   // Clock and reset
   input wire logic        mclk_in,
   input wire logic        rst_in,
   // Write channels
   input wire logic [7:0]  s_axi_awaddr_in,
   input wire logic        s_axi_awvalid_in,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0]  s_axi_wstrb_in,
   input wire logic        s_axi_wvalid_in,
   input wire logic        s_axi_bvalid_out,
   // Read channels
   input wire logic [7:0]  s_axi_araddr_in,
   input wire logic        s_axi_arvalid_in,
   input wire logic        s_axi_rvalid_out,
   // Protocol pins
   input wire logic        intrq_out,
   input wire logic        dmarq_out
);
   // ==================================================
   // Command tracking
   logic       wtk, rtk, cmdw, evw, rise;
   logic       act_ff, dma_ff, first_ff, idis_ff, iq_ff;
   logic       nxt_act, nxt_dma, nxt_first, nxt_idis;
   logic [1:0] cnt_ff, nxt_cnt;

   // Offsets 00 cmd, 04 status, 08 data, 0C ctrl, 1C event
   always_comb begin
      wtk = s_axi_awvalid_in & s_axi_wvalid_in & !s_axi_bvalid_out
            & s_axi_wstrb_in[0];
      rtk = s_axi_arvalid_in & !s_axi_rvalid_out;
      cmdw = wtk & (s_axi_awaddr_in == 8'h00) & !act_ff
             & (s_axi_wdata_in[7:2] == 6'h00) & (s_axi_wdata_in[1:0] != 2'h0)
             & (s_axi_wdata_in[1:0] != 2'h3);
      evw = wtk & (s_axi_awaddr_in == 8'h1C);
      rise = intrq_out & !iq_ff;
      nxt_act = act_ff;
      nxt_dma = dma_ff;
      nxt_first = first_ff;
      nxt_idis = idis_ff;
      nxt_cnt = cnt_ff;
      if (cmdw) begin
         nxt_act = 1'h1;
         nxt_dma = s_axi_wdata_in[1];
         nxt_first = s_axi_wdata_in[0];
         nxt_cnt = 2'h0;
      end
      // Abort or finish ends the command seen from here
      if (evw & (s_axi_wdata_in[3] | s_axi_wdata_in[1]))
         nxt_act = 1'h0;
      if (evw & s_axi_wdata_in[0])
         nxt_first = 1'h0;
      if (wtk & (s_axi_awaddr_in == 8'h0C))
         nxt_idis = s_axi_wdata_in[1];
      // Saturates so a third edge cannot wrap back to legal
      if (dma_ff & rise & (cnt_ff != 2'h2))
         nxt_cnt = cnt_ff + 2'h1;
   end

   // Tracking registers
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         act_ff <= 1'h0;
         dma_ff <= 1'h0;
         first_ff <= 1'h0;
         idis_ff <= 1'h0;
         iq_ff <= 1'h0;
         cnt_ff <= 2'h0;
      end else begin
         act_ff <= nxt_act;
         dma_ff <= nxt_dma;
         first_ff <= nxt_first;
         idis_ff <= nxt_idis;
         iq_ff <= intrq_out;
         cnt_ff <= nxt_cnt;
      end
   end

   // ==================================================
   // Properties
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   sequence s_ready;
      evw & s_axi_wdata_in[0];
   endsequence
   sequence s_done;
      evw & s_axi_wdata_in[3] & act_ff & !idis_ff;
   endsequence

   a_cmd_quiet: assert property (cmdw |-> ##[1:3] !intrq_out)
      else $error("intrq still high after command");
   a_first_silent: assert property (
      s_ready ##0 first_ff |=> !intrq_out [*3])
      else $error("intrq raised for first block");
   a_later_irq: assert property (
      s_ready ##0 (act_ff & !dma_ff & !first_ff & !idis_ff)
      |-> ##[1:3] intrq_out)
      else $error("no intrq for later block");
   a_status_ack: assert property (
      rtk & (s_axi_araddr_in == 8'h04) & intrq_out & act_ff
      |-> ##[1:3] !intrq_out)
      else $error("status read left intrq high");
   a_xfer_quiet: assert property (
      wtk & (s_axi_awaddr_in == 8'h08) & act_ff |-> !intrq_out)
      else $error("intrq high during data transfer");
   a_done_irq: assert property (s_done |-> ##[1:3] intrq_out)
      else $error("no intrq at completion");
   a_idis_silent: assert property (
      $rose(intrq_out) |-> !idis_ff)
      else $error("intrq rose while disabled");
   a_dma_quiet: assert property (dmarq_out |-> !intrq_out)
      else $error("intrq high during dma transfer");
   a_dmarq_ready: assert property (
      s_ready ##0 (dma_ff & act_ff) |-> ##[1:3] dmarq_out)
      else $error("dmarq missing after ready");
   a_burst_drop: assert property (
      evw & s_axi_wdata_in[2] & dma_ff |-> ##[1:3] !dmarq_out)
      else $error("dmarq held after burst end");
   a_one_dma_irq: assert property (cnt_ff != 2'h2)
      else $error("second intrq in one dma command");
endmodule

bind podc_core podc_chk podc_chk_inst (
   .mclk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
   .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
   .s_axi_bvalid_out, .s_axi_araddr_in, .s_axi_arvalid_in,
   .s_axi_rvalid_out, .intrq_out, .dmarq_out
);

// *** tb/podc_host.sv ***
// Host adapter model: an AXI4-Lite master with one task per access.
// Assumes the testbench calls its tasks just after a clock edge.
`timescale 1ns/100ps

module podc_host (
   // Clock
   input wire logic         mclk_in,
   // Write channels
   output logic [7:0]       awaddr_out,
   output logic             awvalid_out,
   input wire logic         awready_in,
   output logic [31:0]      wdata_out,
   output logic [3:0]       wstrb_out,
   output logic             wvalid_out,
   input wire logic         wready_in,
   input wire logic [1:0]   bresp_in,
   input wire logic         bvalid_in,
   output logic             bready_out,
   // Read channels
   output logic [7:0]       araddr_out,
   output logic             arvalid_out,
   input wire logic         arready_in,
   input wire logic [31:0]  rdata_in,
   input wire logic [1:0]   rresp_in,
   input wire logic         rvalid_in,
   output logic             rready_out
);
   logic to_flag = 1'h0;

   // Idle bus at time zero
   initial begin
      awaddr_out <= 8'h00;
      awvalid_out <= 1'h0;
      wdata_out <= 32'h0;
      wstrb_out <= 4'hF;
      wvalid_out <= 1'h0;
      bready_out <= 1'h0;
      araddr_out <= 8'h00;
      arvalid_out <= 1'h0;
      rready_out <= 1'h0;
   end

   // Write; released payload is inverted so stale values never match
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic b_done;
      b_done = 1'h0;
      r = 2'h3;
      @(posedge mclk_in);
      awaddr_out <= a;
      wdata_out <= d;
      awvalid_out <= 1'h1;
      wvalid_out <= 1'h1;
      bready_out <= 1'h1;
      for (int n = 0; n < 64 && !b_done; n++) begin
         @(posedge mclk_in);
         if (awvalid_out & awready_in) begin
            awvalid_out <= 1'h0;
            awaddr_out <= ~a;
         end
         if (wvalid_out & wready_in) begin
            wvalid_out <= 1'h0;
            wdata_out <= ~d;
         end
         if (bvalid_in) begin
            b_done = 1'h1;
            r = bresp_in;
         end
      end
      bready_out <= 1'h0;
      if (!b_done)
         to_flag = 1'h1;
      // 400 ns before any status read after a command
      if (a == 8'h00)
         repeat (50) @(posedge mclk_in);
   endtask

   // Read; rready stays up from the start of the access
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      logic r_done;
      r_done = 1'h0;
      d = 32'h0;
      r = 2'h3;
      @(posedge mclk_in);
      araddr_out <= a;
      arvalid_out <= 1'h1;
      rready_out <= 1'h1;
      for (int n = 0; n < 64 && !r_done; n++) begin
         @(posedge mclk_in);
         if (arvalid_out & arready_in) begin
            arvalid_out <= 1'h0;
            araddr_out <= ~a;
         end
         if (rvalid_in) begin
            r_done = 1'h1;
            d = rdata_in;
            r = rresp_in;
         end
      end
      rready_out <= 1'h0;
      if (!r_done)
         to_flag = 1'h1;
   endtask
endmodule

// *** tb/tb_podc_core.sv ***
// Self-checking bench for the command protocol engine.
// Assumes podc_host drives the bus and podc_chk is bound to the core.
`timescale 1ns/100ps

module tb_podc_core;
   // Row: op (1 read), offset, data, pins {intrq,dmarq,irq}, state
   typedef struct packed {
      logic        op;
      logic [7:0]  a;
      logic [15:0] d;
      logic [2:0]  p;
      logic [6:0]  st;
   } podc_row_s;

   logic        mclk_in = 1'h0;
   logic        rst_in = 1'h1;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, intrq, dmarq, irq;
   int          i, bad_count = 0, comparisons = 0;

   // State 00 means the state is not compared
   podc_row_s rows [0:40] = '{
      '{1'h0,8'h0C,16'h0,3'h0,7'h01}, '{1'h0,8'h14,16'h0,3'h0,7'h01},
      '{1'h0,8'h18,16'h2,3'h0,7'h01}, '{1'h0,8'h00,16'h1,3'h0,7'h04},
      '{1'h1,8'h04,16'h80,3'h0,7'h04}, '{1'h0,8'h1C,16'h1,3'h0,7'h08},
      '{1'h1,8'h04,16'h8,3'h0,7'h08}, '{1'h0,8'h08,16'hA5A5,3'h0,7'h08},
      '{1'h0,8'h08,16'h5A5A,3'h0,7'h04}, '{1'h1,8'h04,16'h80,3'h0,7'h04},
      '{1'h0,8'h1C,16'h1,3'h4,7'h10}, '{1'h1,8'h04,16'h8,3'h0,7'h08},
      '{1'h0,8'h08,16'h1,3'h0,7'h08}, '{1'h0,8'h08,16'h2,3'h0,7'h04},
      '{1'h0,8'h1C,16'h8,3'h4,7'h02}, '{1'h1,8'h04,16'h0,3'h0,7'h00},
      '{1'h1,8'h10,16'h7,3'h0,7'h00}, '{1'h0,8'h14,16'h4,3'h0,7'h00},
      '{1'h0,8'h00,16'h2,3'h0,7'h20}, '{1'h1,8'h04,16'h80,3'h0,7'h20},
      '{1'h0,8'h1C,16'h1,3'h2,7'h40}, '{1'h1,8'h04,16'h8,3'h2,7'h40},
      '{1'h0,8'h1C,16'h4,3'h0,7'h20}, '{1'h0,8'h1C,16'h1,3'h2,7'h40},
      '{1'h0,8'h1C,16'h8,3'h5,7'h02}, '{1'h1,8'h10,16'h5,3'h4,7'h02},
      '{1'h1,8'h04,16'h0,3'h0,7'h00}, '{1'h0,8'h14,16'h0,3'h0,7'h00},
      '{1'h0,8'h0C,16'h2,3'h0,7'h00}, '{1'h0,8'h00,16'h1,3'h0,7'h04},
      '{1'h0,8'h1C,16'h1,3'h0,7'h08}, '{1'h0,8'h08,16'h3,3'h0,7'h08},
      '{1'h0,8'h08,16'h4,3'h0,7'h04}, '{1'h0,8'h1C,16'h1,3'h0,7'h08},
      '{1'h0,8'h08,16'h5,3'h0,7'h08}, '{1'h0,8'h08,16'h6,3'h0,7'h04},
      '{1'h0,8'h1C,16'h2,3'h0,7'h01}, '{1'h1,8'h04,16'h1,3'h0,7'h01},
      '{1'h0,8'h00,16'h2,3'h0,7'h20}, '{1'h0,8'h1C,16'h2,3'h0,7'h01},
      '{1'h1,8'h04,16'h1,3'h0,7'h01}};

   // ==================================================
   // Clock, design and host
   always #4 mclk_in = ~mclk_in;

   podc_core podc_core_inst (
      .mclk_in(mclk_in), .rst_in(rst_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .intrq_out(intrq),
      .dmarq_out(dmarq), .irq_out(irq));

   podc_host podc_host_inst (
      .mclk_in(mclk_in), .awaddr_out(awaddr), .awvalid_out(awvalid),
      .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb),
      .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp),
      .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr),
      .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
      .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));

   // ==================================================
   // Checking and bus helpers
   task automatic tally_and_finish;
      if (bad_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // A wait that runs out ends the run at once
   task automatic bw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic [1:0] r;
      podc_host_inst.wr(a, d, r);
      if (podc_host_inst.to_flag) begin
         bad_count++;
         tally_and_finish;
      end
      chk("bresp", {30'h0, er}, {30'h0, r});
   endtask

   task automatic br(input logic [7:0] a, output logic [31:0] d,
                     input logic [1:0] er);
      logic [1:0] r;
      podc_host_inst.rd(a, d, r);
      if (podc_host_inst.to_flag) begin
         bad_count++;
         tally_and_finish;
      end
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask

   // ==================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge mclk_in);
      rst_in <= 1'h0;
      // Table rows; state read at 1C has no side effect
      for (i = 0; i < 41; i++) begin
         if (rows[i].op) begin
            br(rows[i].a, v, 2'h0);
            chk("rdata", {16'h0, rows[i].d}, v);
         end else
            bw(rows[i].a, {16'h0, rows[i].d}, 2'h0);
         br(8'h1C, v, 2'h0);
         @(negedge mclk_in);
         if (rows[i].st !== 7'h00)
            chk("state", {25'h0, rows[i].st}, v);
         chk("pins", {29'h0, rows[i].p}, {29'h0, intrq, dmarq, irq});
      end
      // Unmapped offset and read-only status
      br(8'h20, v, 2'h2);
      chk("unmapped", 32'h0, v);
      bw(8'h04, 32'h0, 2'h2);
      bw(8'h24, 32'h0, 2'h2);
      // Reset in mid-command must leave a quiet idle device
      bw(8'h00, 32'h1, 2'h0);
      bw(8'h1C, 32'h1, 2'h0);
      @(posedge mclk_in);
      rst_in <= 1'h1;
      repeat (8) @(posedge mclk_in);
      rst_in <= 1'h0;
      br(8'h1C, v, 2'h0);
      chk("state", 32'h1, v);
      br(8'h14, v, 2'h0);
      chk("mask", 32'h0, v);
      br(8'h18, v, 2'h0);
      chk("blklen", 32'h100, {16'h0, v[15:0]});
      br(8'h04, v, 2'h0);
      chk("status", 32'h0, v);
      @(negedge mclk_in);
      chk("pins", 32'h0, {29'h0, intrq, dmarq, irq});
      tally_and_finish;
   end
endmodule
